//--- rt_counter_watchdog_scaler.sv
// Real-time counter, watchdog timer and shared scaler behind an AHB-Lite slave
//
// Function
// R1 - 8-bit counter advances each cycle or on qualifying external pin edge.
// R2 - 8-bit scaler assigned to counter extends its range to 16 bits.
// R3 - Config bit 5 clear counts cycles, set counts external pin edges.
// R4 - Config bit 4 set counts falling edges, clear counts rising edges.
// R5 - Counter wrap from ff to 00 raises an interrupt request.
// R6 - No pending flag records counter overflow; software samples the counter.
// R7 - Writing the counter clears the scaler when scaler belongs to counter.
// R8 - Assign bit 3 set: watchdog clocks scaler, scaler postscales timeout.
// R9 - Assign bit clear: scaler output clocks the counter.
// R10 - Three-bit rate field sets the divide ratio in both assignments.
// R11 - Scaler count is never readable or writable by software.
// R12 - Scaler serves only one of counter or watchdog at a time.
// R13 - Watchdog expiry resets the device and loads the top program address.
// R14 - Return-with-literal adds the literal to the counter value.
// R15 - Rate n divides by 2^(n+1) for counter, 2^n for watchdog.
// R16 - External pin synchronised before edge detect; one increment per edge.
// R17 - Watchdog runs from free time base, requests reset at terminal count; here the base runs only while enabled.
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "rcw_map.svh"

module rt_counter_watchdog_scaler
    import rcw_pkg::*;
#(
    parameter int WDT_BASE_DIV = `WDT_BASE_DIV
) (
    input wire logic i_clk, // Instruction-cycle clock
    input wire logic i_rstn, // Synchronous reset, active low
    input wire logic i_count_pin, // External count pin, asynchronous
    input wire logic i_hsel, // AHB slave select
    input wire logic [31:0] i_haddr, // AHB address
    input wire logic [1:0] i_htrans, // AHB transfer type
    input wire logic i_hwrite, // AHB write
    input wire logic [2:0] i_hsize, // AHB size
    input wire logic [31:0] i_hwdata, // AHB write data
    input wire logic i_hready, // AHB bus ready
    output logic [31:0] o_hrdata, // AHB read data
    output logic o_hreadyout, // AHB ready out
    output logic o_hresp, // AHB response, always OKAY
    output logic o_irq, // Level interrupt from masked status
    output logic o_wrap_irq, // One-cycle counter wrap request
    output logic o_wdt_reset, // One-cycle watchdog reset request
    output logic [10:0] o_reset_vector // Program counter load value
);

    // ****************************************************************
    // State and decode
    // ****************************************************************
    state_t st;
    state_t nx;
    logic wr_cfg;
    logic wr_count;
    logic wr_add;
    logic wr_wdclr;
    logic wr_wdctl;
    logic wr_istat;
    logic wr_imask;
    logic pin_rise;
    logic pin_fall;
    logic src_tick;
    logic cnt_tick;
    logic base_tick;
    logic wdt_ovf;
    logic timeout;
    logic [7:0] cmask;
    logic [7:0] wmask;

    // Low-bit mask of the scaler that marks its terminal count
    function automatic logic [7:0] rate_mask(input logic [2:0] n,
                                             input logic pre);
        logic [8:0] m;
        m = 9'h001 << n;
        if (pre) begin
            m = m << 1;
        end
        return m[7:0] - 8'h01;
    endfunction : rate_mask

    // Data-phase write strobes from the captured address phase
    assign wr_cfg = st.a_sel && st.a_wr && st.a_addr == `CFG_OFS;
    assign wr_count = st.a_sel && st.a_wr && st.a_addr == `COUNT_OFS;
    assign wr_add = st.a_sel && st.a_wr && st.a_addr == `ADD_OFS;
    assign wr_wdclr = st.a_sel && st.a_wr && st.a_addr == `WDCLR_OFS;
    assign wr_wdctl = st.a_sel && st.a_wr && st.a_addr == `WDCTL_OFS;
    assign wr_istat = st.a_sel && st.a_wr && st.a_addr == `ISTAT_OFS;
    assign wr_imask = st.a_sel && st.a_wr && st.a_addr == `IMASK_OFS;

    // ****************************************************************
    // Tick generation
    // ****************************************************************
    // R16 edge detect
    // Only the second sync stage and its delayed copy feed the detector
    assign pin_rise = st.sync[1] && !st.pin_prev;
    assign pin_fall = !st.sync[1] && st.pin_prev;

    // R3 source select, R4 edge select
    assign src_tick = st.cfg[`CFG_SRC_BIT] ?
        (st.cfg[`CFG_EDGE_BIT] ? pin_fall : pin_rise) : 1'b1;

    // R10 rate field, R15 power-of-two ratios
    assign cmask = rate_mask(st.cfg[2:0], 1'b1);
    assign wmask = rate_mask(st.cfg[2:0], 1'b0);

    // R9 scaler clocks counter, R12 bypass when owned by watchdog
    assign cnt_tick = src_tick && (st.cfg[`CFG_ASSIGN_BIT] ||
        (st.scaler & cmask) == cmask);

    // R17 time base, run only while the watchdog is enabled, and terminal count
    assign base_tick = st.base == 16'(WDT_BASE_DIV - 1);
    assign wdt_ovf = st.wdt_en && base_tick && st.wdt == 8'hff;

    // R8 postscaled timeout
    assign timeout = wdt_ovf && (!st.cfg[`CFG_ASSIGN_BIT] ||
        (st.scaler & wmask) == wmask);

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Bus writes win over counting in the same cycle
    always_comb begin
        nx = st;
        nx.sync = {st.sync[0], i_count_pin};
        nx.pin_prev = st.sync[1];
        nx.wrap_irq = 1'b0;
        nx.wdt_reset = 1'b0;
        nx.hresp = 1'b0;
        nx.hready = 1'b1;
        // R2 prescale, R12 scaler follows one owner only
        if (!st.cfg[`CFG_ASSIGN_BIT] && src_tick) begin
            nx.scaler = st.scaler + 8'h01;
        end
        if (st.cfg[`CFG_ASSIGN_BIT] && wdt_ovf) begin
            nx.scaler = st.scaler + 8'h01;
        end
        // R1 count, R5 wrap request, R6 no pending flag kept
        if (cnt_tick) begin
            nx.counter = st.counter + 8'h01;
            nx.wrap_irq = st.counter == 8'hff;
        end
        // R17 time base runs only while the watchdog is enabled
        if (st.wdt_en) begin
            nx.base = base_tick ? 16'h0000 : st.base + 16'h0001;
            if (base_tick) begin
                nx.wdt = st.wdt + 8'h01;
            end
        end else begin
            nx.base = 16'h0000;
            nx.wdt = 8'h00;
        end
        if (wr_cfg) begin
            nx.cfg = i_hwdata[7:0];
        end
        // R7 counter write clears an attached scaler
        if (wr_count) begin
            nx.counter = i_hwdata[7:0];
            nx.wrap_irq = 1'b0;
            if (!st.cfg[`CFG_ASSIGN_BIT]) begin
                nx.scaler = 8'h00;
            end
        end
        // R14 literal added on interrupt return
        if (wr_add) begin
            nx.counter = st.counter + i_hwdata[7:0];
            nx.wrap_irq = 1'b0;
        end
        if (wr_wdclr) begin
            nx.base = 16'h0000;
            nx.wdt = 8'h00;
            if (st.cfg[`CFG_ASSIGN_BIT]) begin
                nx.scaler = 8'h00;
            end
        end
        if (wr_wdctl) begin
            nx.wdt_en = i_hwdata[0];
        end
        if (wr_imask) begin
            nx.mask = i_hwdata[0];
        end
        // Set beats a write-one clear in the same cycle
        nx.status = (st.status & !(wr_istat && i_hwdata[0])) | timeout;
        // R13 expiry reinitialises config and watchdog, loads vector
        if (timeout) begin
            nx.cfg = `CFG_RESET;
            nx.wdt = 8'h00;
            nx.base = 16'h0000;
            nx.scaler = 8'h00;
            nx.wdt_reset = 1'b1;
            nx.vector = `RESET_VECTOR;
        end
        nx.irq = nx.status && nx.mask;
        // Address phase capture, whole-word transfers only
        nx.a_sel = i_hsel && i_hready && i_htrans[1] && i_hsize == 3'b010;
        nx.a_wr = i_hwrite;
        nx.a_addr = i_haddr[7:0];
        // R11 read mux has no scaler entry; reads see this cycle's writes
        if (nx.a_sel && !i_hwrite) begin
            case (i_haddr[7:0])
                `CFG_OFS: nx.hrdata = {24'h000000, nx.cfg};
                `COUNT_OFS: nx.hrdata = {24'h000000, nx.counter};
                `WDCTL_OFS: nx.hrdata = {31'h00000000, nx.wdt_en};
                `ISTAT_OFS: nx.hrdata = {31'h00000000, nx.status};
                `IMASK_OFS: nx.hrdata = {31'h00000000, nx.mask};
                default: nx.hrdata = 32'h00000000;
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Reset loads constants only
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st <= '0;
            st.cfg <= `CFG_RESET;
            st.vector <= `RESET_VECTOR;
            st.hready <= 1'b1;
        end else begin
            st <= nx;
        end
    end

    // Outputs straight from the state flops
    assign o_hrdata = st.hrdata;
    assign o_hreadyout = st.hready;
    assign o_hresp = st.hresp;
    assign o_irq = st.irq;
    assign o_wrap_irq = st.wrap_irq;
    assign o_wdt_reset = st.wdt_reset;
    assign o_reset_vector = st.vector;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    property p_count_step;
        (cnt_tick && !wr_count && !wr_add && !timeout)
            |=> st.counter == $past(st.counter) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step) // R1
        else $error("Counter did not advance on tick");

    property p_wrap_irq;
        (cnt_tick && st.counter == 8'hff && !wr_count && !wr_add)
            |=> o_wrap_irq && st.counter == 8'h00;
    endproperty
    a_wrap_irq: assert property (p_wrap_irq) // R5
        else $error("Wrap did not raise request");

    property p_wrap_only_on_wrap;
        o_wrap_irq |-> st.counter == 8'h00 && $past(st.counter) == 8'hff;
    endproperty
    a_wrap_only_on_wrap: assert property (p_wrap_only_on_wrap) // R6
        else $error("Wrap request without wrap");

    property p_write_clears_scaler;
        (wr_count && !st.cfg[`CFG_ASSIGN_BIT]) |=> st.scaler == 8'h00;
    endproperty
    a_write_clears_scaler: assert property (p_write_clears_scaler) // R7
        else $error("Counter write left scaler");

    property p_bypass_when_wdt;
        (st.cfg[`CFG_ASSIGN_BIT] && !st.cfg[`CFG_SRC_BIT]) |-> cnt_tick;
    endproperty
    a_bypass_when_wdt: assert property (p_bypass_when_wdt) // R12
        else $error("Scaler still in counter path");

    property p_div2;
        (!st.cfg[`CFG_ASSIGN_BIT] && !st.cfg[`CFG_SRC_BIT] &&
         st.cfg[2:0] == 3'h0 && cnt_tick && !wr_cfg && !wr_count &&
         !timeout)
            |=> !cnt_tick;
    endproperty
    a_div2: assert property (p_div2) // R15
        else $error("Rate 0 did not divide by two");

    property p_pin_fall;
        (st.cfg[`CFG_SRC_BIT] && st.cfg[`CFG_EDGE_BIT] && !wr_cfg &&
         !timeout && $fell(i_count_pin)) |-> ##2 (src_tick || $past(wr_cfg));
    endproperty
    a_pin_fall: assert property (p_pin_fall) // R16
        else $error("Falling pin edge not seen two cycles later");

    property p_timeout_reset;
        timeout |=> o_wdt_reset && o_reset_vector == `RESET_VECTOR
            && st.cfg == `CFG_RESET ##1 !o_wdt_reset;
    endproperty
    a_timeout_reset: assert property (p_timeout_reset) // R13
        else $error("Timeout did not give one reset pulse");

    property p_wdt_clear;
        (wr_wdclr && !timeout) |=> st.wdt == 8'h00 && st.base == 16'h0000;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) // R17
        else $error("Watchdog clear ignored");

    property p_add_literal;
        (wr_add && !timeout)
            |=> st.counter == $past(st.counter) + $past(i_hwdata[7:0]);
    endproperty
    a_add_literal: assert property (p_add_literal) // R14
        else $error("Literal not added to counter");

    c_wrap: cover property (o_wrap_irq);
    c_wdt_reset: cover property (o_wdt_reset);
    c_ext_tick: cover property (st.cfg[`CFG_SRC_BIT] && cnt_tick);
    c_irq: cover property (o_irq);

endmodule : rt_counter_watchdog_scaler

`default_nettype wire

//--- rcw_map.svh
// Offsets, field positions, reset values and timing counts of the counter block
`ifndef RCW_MAP_SVH
`define RCW_MAP_SVH

// ****************************************************************
// Register byte offsets (low address byte decoded)
// ****************************************************************
`define CFG_OFS 8'h00
`define COUNT_OFS 8'h04
`define ADD_OFS 8'h08
`define WDCLR_OFS 8'h0c
`define WDCTL_OFS 8'h10
`define ISTAT_OFS 8'h14
`define IMASK_OFS 8'h18

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CFG_SRC_BIT 5
`define CFG_EDGE_BIT 4
`define CFG_ASSIGN_BIT 3
`define CFG_RESET 8'hff
`define RESET_VECTOR 11'h7ff

// ****************************************************************
// Timing counts
// ****************************************************************
`define WDT_BASE_DIV 256

`endif

//--- rcw_pkg.sv
// Types shared by the counter, watchdog and scaler block
`default_nettype none
package rcw_pkg;

    // Whole state of the block, registered as one word
    typedef struct packed {
        logic [1:0] sync;
        logic pin_prev;
        logic [7:0] cfg;
        logic [7:0] counter;
        logic [7:0] scaler;
        logic [15:0] base;
        logic [7:0] wdt;
        logic wdt_en;
        logic status;
        logic mask;
        logic irq;
        logic wrap_irq;
        logic wdt_reset;
        logic [10:0] vector;
        logic a_sel;
        logic a_wr;
        logic [7:0] a_addr;
        logic [31:0] hrdata;
        logic hready;
        logic hresp;
    } state_t;

endpackage : rcw_pkg

`default_nettype wire

//--- count_pin_model.sv
// Behavioural source for the external count pin
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Count pin source
// ****************************************************************
module count_pin_model (
    input wire logic i_clk, // Instruction clock
    output logic o_pin // Level driven onto the count pin
);
    // Pin idles low until the bench asks for an edge
    initial o_pin = 1'b0;

    // hold past sync
    // Each level stands four cycles, so the edge has passed the two-flop
    // synchroniser and edge stage into the counter before the bench reads it
    task automatic set_level(input logic lvl);
        @(posedge i_clk);
        o_pin <= lvl;
        repeat (4) @(posedge i_clk);
    endtask : set_level
endmodule : count_pin_model
`default_nettype wire

//--- tb_rt_counter_watchdog_scaler.sv
// Self-checking bench for the counter, watchdog and shared scaler
`timescale 1ns/10ps
`default_nettype none
`include "rcw_map.svh"

`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end

module tb_rt_counter_watchdog_scaler;
    localparam int BASE = 2;
    logic i_clk = 1'b0;
    logic i_rstn, hsel, hwrite, hreadyout, hresp, irq, wrap, wdt_rst, pin;
    logic [31:0] haddr, hwdata, hrdata, q, q0;
    logic [1:0] htrans;
    logic [10:0] vector;
    int fails = 0, num_checks = 0, seed = 26790, wraps = 0, resets = 0;
    int n, k, t0, t2, ta;

    // ****************************************************************
    // Clock, design, partner and monitors
    // ****************************************************************
    always #10 i_clk = ~i_clk;

    rt_counter_watchdog_scaler #(.WDT_BASE_DIV(BASE))
        u_rt_counter_watchdog_scaler (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_count_pin(pin), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
        .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .o_irq(irq), .o_wrap_irq(wrap), .o_wdt_reset(wdt_rst),
        .o_reset_vector(vector));

    count_pin_model u_count_pin_model (.i_clk(i_clk), .o_pin(pin));

    // Pulse counters, sampled on the edge so each pulse counts once
    always @(posedge i_clk) begin
        if (wrap === 1'b1) wraps++;
        if (wdt_rst === 1'b1) resets++;
    end

    // One AHB-Lite single word transfer; read data taken at data edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge i_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge i_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge i_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus

    // Full pin pulse: one rising and one falling edge
    task automatic pulse();
        u_count_pin_model.set_level(1'b1);
        u_count_pin_model.set_level(1'b0);
    endtask : pulse

    // Cycles from a watchdog clear to its reset request
    task automatic wd(input logic [7:0] c, output int t);
        bus(1'b1, `CFG_OFS, {24'h0, c}, q);
        bus(1'b1, `WDCLR_OFS, 32'h0, q);
        t = 0;
        while (wdt_rst !== 1'b1 && t < 30000) begin
            @(posedge i_clk);
            #1;
            t++;
        end
        // A watchdog that never fires is a failure in itself
        if (t >= 30000) fails++;
    endtask : wd

    task automatic print_verdict();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // Hang guard, well past the longest watchdog span
    initial begin
        #(20 * 90000);
        fails++;
        print_verdict();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        i_rstn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
        hwrite = 1'b0; hwdata = 32'h0;
        repeat (8) @(posedge i_clk);
        i_rstn <= 1'b1;
        bus(1'b0, `CFG_OFS, 32'h0, q);
        `CHK("cfg", 32'hff, q)
        `CHK("vector", 11'h7ff, vector)
        // Scaler count lives at no address: holes read zero
        for (int i = 7; i < 10; i++) begin
            bus(1'b1, 8'(i * 4), 32'hff, q);
            bus(1'b0, 8'(i * 4), 32'h0, q);
            `CHK("hole", 32'h0, q)
            `CHK("hresp", 1'b0, hresp)
        end
        // Scaler on watchdog: counter takes every instruction cycle
        bus(1'b1, `CFG_OFS, 32'h08, q);
        k = $random(seed) & 15;
        bus(1'b0, `COUNT_OFS, 32'h0, q0);
        repeat (k) @(posedge i_clk);
        bus(1'b0, `COUNT_OFS, 32'h0, q);
        `CHK("count", 8'(q0 + k + 3), q[7:0])
        // Prescaled cycles: span is a whole number of scaler periods
        n = $random(seed) & 3;
        k = 2 + ($random(seed) & 3);
        bus(1'b1, `CFG_OFS, 32'(n), q);
        bus(1'b0, `COUNT_OFS, 32'h0, q0);
        repeat ((2 << n) * k - 3) @(posedge i_clk);
        bus(1'b0, `COUNT_OFS, 32'h0, q);
        `CHK("prescaled", 8'(q0 + k), q[7:0])
        // Edge choice: the unselected edge leaves the counter alone
        for (int f = 0; f < 2; f++) begin
            u_count_pin_model.set_level(!f);
            bus(1'b1, `CFG_OFS, 32'h28 | (f << 4), q);
            bus(1'b1, `COUNT_OFS, 32'h0, q);
            u_count_pin_model.set_level(f[0]);
            bus(1'b0, `COUNT_OFS, 32'h0, q);
            `CHK("off edge", 32'h0, q)
            u_count_pin_model.set_level(!f);
            bus(1'b0, `COUNT_OFS, 32'h0, q);
            `CHK("on edge", 32'h1, q)
        end
        // Partial scaler count must be lost by the counter write
        n = $random(seed) & 1;
        k = 1 + ($random(seed) & 1);
        bus(1'b1, `CFG_OFS, 32'h20 | n, q);
        repeat ((2 << n) - 1) pulse();
        bus(1'b1, `COUNT_OFS, 32'h0, q);
        repeat ((2 << n) * k - 1) pulse();
        bus(1'b0, `COUNT_OFS, 32'h0, q);
        `CHK("scaled pin", 32'(k - 1), q)
        // Wrap by counting pulses; wrap by adding does not
        bus(1'b1, `CFG_OFS, 32'h28, q);
        bus(1'b1, `COUNT_OFS, 32'hff, q);
        k = wraps;
        pulse();
        `CHK("wraps", k + 1, wraps)
        bus(1'b0, `COUNT_OFS, 32'h0, q);
        `CHK("wrapped", 32'h0, q)
        bus(1'b0, `ISTAT_OFS, 32'h0, q);
        `CHK("no pending", 32'h0, q)
        bus(1'b1, `COUNT_OFS, 32'hfe, q);
        bus(1'b1, `ADD_OFS, 32'h05, q);
        bus(1'b0, `COUNT_OFS, 32'h0, q);
        `CHK("added", 32'h03, q)
        `CHK("add wraps", k + 1, wraps)
        // Watchdog spans: postscale only when assigned to watchdog
        bus(1'b1, `WDCTL_OFS, 32'h1, q);
        wd(8'h08, t0);
        bus(1'b0, `CFG_OFS, 32'h0, q);
        `CHK("cfg after", 32'hff, q)
        `CHK("vector", 11'h7ff, vector)
        bus(1'b0, `ISTAT_OFS, 32'h0, q);
        `CHK("timeout", 32'h1, q)
        wd(8'h0a, t2);
        `CHK("postscale", 3 * BASE * 256, t2 - t0)
        wd(8'h03, ta);
        `CHK("no postscale", t0, ta)
        // Regular clearing keeps the watchdog quiet
        bus(1'b1, `CFG_OFS, 32'h08, q);
        k = resets;
        repeat (6) begin
            bus(1'b1, `WDCLR_OFS, 32'h0, q);
            repeat (300) @(posedge i_clk);
        end
        `CHK("cleared", k, resets)
        // Interrupt level follows status and mask
        bus(1'b1, `WDCTL_OFS, 32'h0, q);
        bus(1'b1, `IMASK_OFS, 32'h1, q);
        @(posedge i_clk);
        #1;
        `CHK("irq on", 1'b1, irq)
        bus(1'b1, `IMASK_OFS, 32'h0, q);
        @(posedge i_clk);
        #1;
        `CHK("irq masked", 1'b0, irq)
        bus(1'b1, `IMASK_OFS, 32'h1, q);
        bus(1'b1, `ISTAT_OFS, 32'h1, q);
        @(posedge i_clk);
        #1;
        `CHK("irq cleared", 1'b0, irq)
        bus(1'b0, `ISTAT_OFS, 32'h0, q);
        `CHK("status", 32'h0, q)
        print_verdict();
    end
endmodule : tb_rt_counter_watchdog_scaler
`default_nettype wire
